// ===== common/popr_pkg.sv
package popr_pkg;
    // ***********************************************
    // configuration word layout
    // ***********************************************
    localparam int unsigned CFG_W = 24;
    localparam int unsigned ADDR_LSB = 0;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned FMT_LSB = 16;
    localparam int unsigned FMT_W = 7;
    localparam int unsigned HALL_EN_BIT = 23;
    localparam int unsigned HALL_DIR_BIT = 22;
    localparam int unsigned HALL_OFS_LSB = 16;
    localparam int unsigned HALL_OFS_W = 6;
    // ***********************************************
    // hall inputs inside the flag word
    // ***********************************************
    localparam int unsigned HALL_U_BIT = 22;
    localparam int unsigned HALL_V_BIT = 21;
    localparam int unsigned HALL_W_BIT = 20;
    localparam int unsigned SECT_W = 3;
    localparam logic [2:0] SECT_LAST = 3'h5;
    localparam logic [2:0] SECT_COUNT = 3'h6;
    // ***********************************************
    // data widths and modes
    // ***********************************************
    localparam int unsigned POS_W = 24;
    localparam int unsigned MULT_W = 8;
    localparam int unsigned ENC_W = 8;
    localparam int unsigned MODE_W = 2;
    localparam logic [1:0] MODE_AUTO_ON = 2'h1;
    localparam logic [CFG_W-1:0] CFG_NONE = 24'h000000;
    localparam logic [POS_W-1:0] POS_RESET = 24'h000000;

    typedef enum logic [3:0] {
        POPR_START = 4'h1,
        POPR_REQ = 4'h2,
        POPR_APPLY = 4'h4,
        POPR_RUN = 4'h8
    } popr_state_t;

    typedef struct packed {
        logic req;
        logic hall_space;
        logic [ADDR_W-1:0] addr;
        logic [FMT_W-1:0] fmt;
    } popr_sensor_req_t;

    typedef struct packed {
        popr_state_t state;
        logic [POS_W-1:0] phase_pos;
        logic [POS_W-1:0] data;
        logic enabled;
        logic closed_loop;
        logic by_cmd;
        logic hall_invalid;
        logic [SECT_W-1:0] sector;
        logic hall_space;
        logic [ADDR_W-1:0] addr;
        logic [FMT_W-1:0] fmt;
    } popr_regs_t;
endpackage

// ===== hdl/popr_hall_decode.sv
`timescale 1ns/1ps
module popr_hall_decode
(
    // flag word and sense
    input wire logic [popr_pkg::CFG_W-1:0] flags_in,
    input wire logic reverse_in,
    // decoded sector
    output logic [popr_pkg::SECT_W-1:0] sector_out,
    output logic valid_out
);
    import popr_pkg::*;
    logic [2:0] uvw;
    logic [SECT_W-1:0] fwd;

    always_comb
    begin
        uvw = {flags_in[HALL_U_BIT], flags_in[HALL_V_BIT], flags_in[HALL_W_BIT]};
        valid_out = 1'b1;
        // zero at v edge, u low
        case (uvw)
            3'h3: fwd = 3'h0;
            3'h2: fwd = 3'h1;
            3'h6: fwd = 3'h2;
            3'h4: fwd = 3'h3;
            3'h5: fwd = 3'h4;
            3'h1: fwd = 3'h5;
            default:
            begin
                fwd = 3'h0;
                valid_out = 1'b0;
            end
        endcase
        if (reverse_in && fwd != 3'h0)
        begin
            sector_out = SECT_COUNT - fwd;
        end
        else
        begin
            sector_out = fwd;
        end
    end
endmodule // popr_hall_decode

// ===== hdl/popr_phase_ref.sv
`timescale 1ns/1ps
// Overview of operation
// - A nonzero phase source word makes the block read the sensor at its address and format at reset.
// - The reset reading times the cycle multiplier plus the stored offset goes into the phase position.
// - The sensor is read only at card reset or motor reset; afterwards the phase follows the encoder counter.
// - With power-on mode 1 the motor is enabled in closed loop right after a card reset, except when the hall code read is invalid.
// - With power-on mode 0 the read is done at reset but the motor stays disabled until motor reset, open-loop or jog.
// - A motor reset command performs a fresh absolute read and enables closed loop, except when that read finds an invalid hall code.
// - Bit 23 of the source word selects hall referencing with the address taken in X space.
// - Hall U, V and W are bits 22, 21 and 20 of the addressed flag word.
// - Bit 22 of the source word picks standard or reversed hall sense.
// - Bits 16 to 21 hold a hall zero offset in sixty-fourths of a commutation cycle.
// - The V edge while U is low is hall zero, phase zero with no offset.
module popr_phase_ref
(
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // configuration
    input wire logic [popr_pkg::CFG_W-1:0] phase_source_config_in,
    input wire logic [popr_pkg::POS_W-1:0] phase_offset_value_in,
    input wire logic [popr_pkg::MULT_W-1:0] cycle_multiplier_in,
    input wire logic [popr_pkg::POS_W-1:0] commutation_cycle_in,
    input wire logic [popr_pkg::MODE_W-1:0] power_on_phasing_mode_in,
    // commands
    input wire logic motor_reset_cmd_in,
    input wire logic open_loop_cmd_in,
    input wire logic jog_cmd_in,
    // encoder counter
    input wire logic [popr_pkg::ENC_W-1:0] enc_delta_in,
    // sensor read port
    output popr_pkg::popr_sensor_req_t sensor_req_out,
    input wire logic sensor_ack_in,
    input wire logic [popr_pkg::CFG_W-1:0] sensor_data_in,
    // status
    output logic [popr_pkg::POS_W-1:0] phase_pos_out,
    output logic motor_enabled_out,
    output logic closed_loop_out,
    output logic hall_invalid_out,
    output logic [popr_pkg::SECT_W-1:0] hall_sector_out,
    output logic busy_out
);
    import popr_pkg::*;

    // ***********************************************
    // state
    // ***********************************************
    popr_regs_t s_reg;
    popr_regs_t s_next;
    logic [SECT_W-1:0] sector;
    logic hall_ok;
    logic [POS_W-1:0] abs_sum;
    logic [POS_W-1:0] enc_step;
    logic [POS_W-1:0] hall_phase;
    logic [HALL_OFS_W-1:0] pos64;
    logic [31:0] hall_prod;
    logic [31:0] abs_prod;
    logic [31:0] enc_prod;
    logic auto_on;

    // sixty-fourths at the start of each sector
    function automatic logic [HALL_OFS_W-1:0] sect64(input logic [SECT_W-1:0] s);
        case (s)
            3'h0: sect64 = 6'h00;
            3'h1: sect64 = 6'h0B;
            3'h2: sect64 = 6'h15;
            3'h3: sect64 = 6'h20;
            3'h4: sect64 = 6'h2B;
            SECT_LAST: sect64 = 6'h35;
            default: sect64 = 6'h00;
        endcase
    endfunction

    // ***********************************************
    // hall decode
    // ***********************************************
    // u v w from flag word
    popr_hall_decode u_hall
    (
        .flags_in(s_reg.data),
        .reverse_in(phase_source_config_in[HALL_DIR_BIT]),
        .sector_out(sector),
        .valid_out(hall_ok)
    );

    // ***********************************************
    // arithmetic
    // ***********************************************
    always_comb
    begin
        abs_prod = 32'(signed'(s_reg.data)) * 32'(cycle_multiplier_in);
        abs_sum = abs_prod[POS_W-1:0] + phase_offset_value_in;
        enc_prod = 32'(signed'(enc_delta_in)) * 32'(cycle_multiplier_in);
        enc_step = enc_prod[POS_W-1:0];
        pos64 = sect64(sector) + phase_source_config_in[HALL_OFS_LSB +: HALL_OFS_W];
        hall_prod = 32'(pos64) * 32'(commutation_cycle_in);
        hall_phase = hall_prod[HALL_OFS_W +: POS_W];
        auto_on = power_on_phasing_mode_in == MODE_AUTO_ON;
    end

    // ***********************************************
    // sequencer
    // ***********************************************
    always_comb
    begin
        s_next = s_reg;
        case (s_reg.state)
            POPR_START:
            begin
                s_next.addr = phase_source_config_in[ADDR_LSB +: ADDR_W];
                s_next.fmt = phase_source_config_in[FMT_LSB +: FMT_W];
                s_next.hall_space = phase_source_config_in[HALL_EN_BIT];
                s_next.enabled = 1'b0;
                s_next.closed_loop = 1'b0;
                if (phase_source_config_in != CFG_NONE)
                begin
                    s_next.state = POPR_REQ;
                end
                else
                begin
                    s_next.state = POPR_RUN;
                    s_next.enabled = s_reg.by_cmd || auto_on;
                    s_next.closed_loop = s_reg.by_cmd || auto_on;
                end
            end
            POPR_REQ:
            begin
                if (sensor_ack_in)
                begin
                    s_next.data = sensor_data_in;
                    s_next.state = POPR_APPLY;
                end
            end
            POPR_APPLY:
            begin
                s_next.state = POPR_RUN;
                s_next.hall_invalid = 1'b0;
                if (s_reg.hall_space)
                begin
                    s_next.sector = sector;
                    s_next.hall_invalid = !hall_ok;
                    if (hall_ok)
                    begin
                        s_next.phase_pos = hall_phase;
                    end
                end
                else
                begin
                    s_next.phase_pos = abs_sum;
                end
                s_next.enabled = (s_reg.by_cmd || auto_on) && s_next.hall_invalid == 1'b0;
                s_next.closed_loop = s_next.enabled;
            end
            POPR_RUN:
            begin
                s_next.phase_pos = s_reg.phase_pos + enc_step;
                if (motor_reset_cmd_in)
                begin
                    s_next.by_cmd = 1'b1;
                    s_next.state = POPR_START;
                end
                else if (jog_cmd_in)
                begin
                    s_next.enabled = 1'b1;
                    s_next.closed_loop = 1'b1;
                end
                else if (open_loop_cmd_in)
                begin
                    s_next.enabled = 1'b1;
                    s_next.closed_loop = 1'b0;
                end
            end
            default:
            begin
                s_next.state = POPR_START;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            s_reg <= '{state: POPR_START, phase_pos: POS_RESET, data: POS_RESET, default: '0};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ***********************************************
    // outputs
    // ***********************************************
    always_comb
    begin
        sensor_req_out.req = s_reg.state == POPR_REQ;
        sensor_req_out.hall_space = s_reg.hall_space;
        sensor_req_out.addr = s_reg.addr;
        sensor_req_out.fmt = s_reg.fmt;
        phase_pos_out = s_reg.phase_pos;
        motor_enabled_out = s_reg.enabled;
        closed_loop_out = s_reg.closed_loop;
        hall_invalid_out = s_reg.hall_invalid;
        hall_sector_out = s_reg.sector;
        busy_out = s_reg.state != POPR_RUN;
    end

    // ***********************************************
    // checks
    // ***********************************************
    // read follows start
    a_start_reads: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_reg.state == POPR_START && phase_source_config_in != CFG_NONE) |=> sensor_req_out.req)
        else $error("no sensor read after start");
    a_abs_sum: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_reg.state == POPR_APPLY && !s_reg.hall_space) |=> phase_pos_out == $past(abs_sum))
        else $error("phase not set to reading plus offset");
    a_no_run_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(sensor_req_out.req) |-> $past(s_reg.state) == POPR_START)
        else $error("sensor read outside reset");
    a_enc_track: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_reg.state == POPR_RUN && !motor_reset_cmd_in) |=> phase_pos_out == $past(phase_pos_out) + $past(enc_step))
        else $error("phase not tracking encoder");
    a_mode_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_reg.state == POPR_APPLY && !s_reg.by_cmd && auto_on && !s_reg.hall_space) |=> motor_enabled_out && closed_loop_out)
        else $error("mode 1 did not enable closed loop");
    a_mode_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_reg.state == POPR_APPLY && !s_reg.by_cmd && !auto_on) |=> !motor_enabled_out)
        else $error("mode 0 enabled the motor");
    a_cmd_reread: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_reg.state == POPR_RUN && motor_reset_cmd_in && phase_source_config_in != CFG_NONE) |=> ##1 sensor_req_out.req)
        else $error("motor reset did not reread sensor");
    a_hall_space: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_reg.state == POPR_START) |=> sensor_req_out.hall_space == $past(phase_source_config_in[HALL_EN_BIT]))
        else $error("hall space select wrong");
    a_hall_bad: assert property (@(posedge clk_in) disable iff (!resetn_in)
        (s_reg.state == POPR_APPLY && s_reg.hall_space && !hall_ok) |=> hall_invalid_out && !motor_enabled_out)
        else $error("invalid hall code not flagged");
endmodule // popr_phase_ref

// ===== tb/popr_sensor_model.sv
`timescale 1ns/1ps
// ***********************************************
// absolute or hall sensor at the far side
// ***********************************************
module popr_sensor_model
(
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // read request and answer
    input wire popr_pkg::popr_sensor_req_t req_in,
    input wire logic [3:0] delay_in,
    input wire logic [popr_pkg::CFG_W-1:0] word_in,
    output logic ack_out,
    output logic [popr_pkg::CFG_W-1:0] data_out
);
    import popr_pkg::*;
    logic [3:0] cnt_reg;
    always @(negedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ack_out <= 1'b0;
            cnt_reg <= 4'h0;
            data_out <= 24'h000000;
        end
        else if (req_in.req && !ack_out && cnt_reg >= delay_in)
        begin
            ack_out <= 1'b1;
            cnt_reg <= 4'h0;
            data_out <= word_in;
        end
        else
        begin
            ack_out <= 1'b0;
            cnt_reg <= req_in.req ? cnt_reg + 4'h1 : 4'h0;
            data_out <= ~data_out;
        end
    end
endmodule // popr_sensor_model

// ===== tb/test_power_on_phase_reference.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module test_power_on_phase_reference;
    import popr_pkg::*;
    logic clk = 1'b0;
    logic resetn, rst_cmd, ol_cmd, jog_cmd, ack, en, cl, inv, busy;
    logic [23:0] cfg, offs, cyc, word, sdata, phase, p;
    logic [7:0] mult, enc;
    logic [1:0] mode;
    logic [3:0] dly;
    logic [2:0] sect;
    popr_sensor_req_t req;
    int err_total = 0, checks = 0, cycles = 0, k, c, d, s, j, ei;
    int seed;
    int codes[$] = '{3, 2, 6, 4, 5, 1};
    int starts[$] = '{0, 11, 21, 32, 43, 53};
    popr_phase_ref u_popr_phase_ref (.clk_in(clk), .resetn_in(resetn), .phase_source_config_in(cfg),
        .phase_offset_value_in(offs), .cycle_multiplier_in(mult), .commutation_cycle_in(cyc),
        .power_on_phasing_mode_in(mode), .motor_reset_cmd_in(rst_cmd), .open_loop_cmd_in(ol_cmd),
        .jog_cmd_in(jog_cmd), .enc_delta_in(enc), .sensor_req_out(req), .sensor_ack_in(ack),
        .sensor_data_in(sdata), .phase_pos_out(phase), .motor_enabled_out(en), .closed_loop_out(cl),
        .hall_invalid_out(inv), .hall_sector_out(sect), .busy_out(busy));
    popr_sensor_model u_popr_sensor_model (.clk_in(clk), .resetn_in(resetn), .req_in(req),
        .delay_in(dly), .word_in(word), .ack_out(ack), .data_out(sdata));
    always #5 clk = ~clk;
    // ***********************************************
    // hang guard
    // ***********************************************
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (err_total == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic do_reset();
        resetn = 1'b0;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
    endtask
    task automatic cmd(input int n);
        rst_cmd = (n == 0);
        ol_cmd = (n == 1);
        jog_cmd = (n == 2);
        @(negedge clk);
        {rst_cmd, ol_cmd, jog_cmd} = 3'h0;
        @(negedge clk);
    endtask
    task automatic wait_run();
        int i;
        i = 0;
        while (busy !== 1'b0 && i < 200)
        begin
            if (req.req === 1'b1)
                `CHK({req.hall_space, req.addr, req.fmt}, {cfg[23], cfg[15:0], cfg[22:16]})
            @(negedge clk);
            i++;
        end
        `CHK(busy, 1'b0)
    endtask
    // ***********************************************
    // scenarios
    // ***********************************************
    initial
    begin
        seed = 32'h87A5EA0C;
        {cfg, offs, cyc, word, mult, enc, mode, dly, rst_cmd, ol_cmd, jog_cmd} = '0;
        // absolute reads, prompt and slow, both power-on modes
        for (k = 0; k < 4; k++)
        begin
            cfg = {1'b0, 7'($random(seed)), 16'($random(seed)) | 16'h0001};
            word = 24'($random(seed));
            mult = 8'($random(seed));
            dly = 4'(k * 5);
            mode = 2'(k % 2);
            offs = (k == 3) ? 24'(-(word * mult)) : 24'($random(seed));
            do_reset();
            wait_run();
            `CHK(phase, 24'(word * mult + offs))
            `CHK({en, cl}, {2{mode == 2'h1}})
            if (k == 3)
                `CHK(phase, 24'h000000)
        end
        mode = 2'h0;
        do_reset();
        wait_run();
        `CHK({en, cl}, 2'h0)
        cmd(1);
        `CHK({en, cl}, 2'h2)
        cmd(2);
        `CHK({en, cl}, 2'h3)
        word = 24'($random(seed));
        rst_cmd = 1'b1;
        @(negedge clk);
        rst_cmd = 1'b0;
        `CHK(busy, 1'b1)
        wait_run();
        `CHK(phase, 24'(word * mult + offs))
        `CHK({en, cl}, 2'h3)
        // encoder tracking in run
        for (k = 0; k < 30; k++)
        begin
            p = phase;
            enc = 8'($random(seed));
            ei = $signed(enc);
            @(negedge clk);
            `CHK(phase, 24'(int'(p) + ei * int'(mult)))
            `CHK(req.req, 1'b0)
        end
        enc = 8'h00;
        // every hall code in both senses
        cyc = 24'h000400;
        for (d = 0; d < 2; d++)
            for (c = 0; c < 8; c++)
            begin
                cfg = {1'b1, 1'(d), 6'($random(seed)), 16'hC004};
                word = {1'($random(seed)), 3'(c), 20'($random(seed))};
                p = phase;
                cmd(0);
                wait_run();
                s = -1;
                for (j = 0; j < 6; j++)
                    if (codes[j] == c)
                        s = j;
                if (s < 0)
                begin
                    `CHK({inv, en}, 2'h2)
                    `CHK(phase, p)
                end
                else
                begin
                    s = (d == 1) ? (6 - s) % 6 : s;
                    `CHK(sect, 3'(s))
                    `CHK({inv, en, cl}, 3'h3)
                    `CHK(phase, 24'(((starts[s] + int'(cfg[21:16])) % 64) * 16))
                end
            end
        // zero source word: no read at all
        cfg = 24'h000000;
        mode = 2'h1;
        do_reset();
        @(negedge clk);
        `CHK(req.req, 1'b0)
        wait_run();
        `CHK({phase, en}, {24'h000000, 1'b1})
        print_verdict();
    end
endmodule // test_power_on_phase_reference
